//--- src/bbco_map.svh
/*
  Encodings, status bit positions, reset values and phase figures for the
  bit, branch, call and clear execution block.
  Assumes inclusion by bare name from the design file.
*/
`ifndef BBCO_MAP_SVH
`define BBCO_MAP_SVH

`define BBCO_OPC_BITINV 4'h7
`define BBCO_OPC_BOV 8'hE4
`define BBCO_OPC_BNULL 8'hE0
`define BBCO_OPC_CALL 7'h76
`define BBCO_OPC_CALL2 4'hF
`define BBCO_OPC_FILE_CLEAR_OP 7'h35
`define BBCO_OPC_WATCHDOG_CLEAR_OP 16'h0004
`define BBCO_OPC_FILE_INVERT_OP 6'h07

`define BBCO_ST_C 0
`define BBCO_ST_DC 1
`define BBCO_ST_Z 2
`define BBCO_ST_OV 3
`define BBCO_ST_N 4

`define BBCO_ACCESS_SPLIT 8'h60
`define BBCO_INDEX_LIMIT 8'h5F
`define BBCO_ACCESS_HIGH_BANK 4'hF
`define BBCO_PC_STEP 21'h000002
`define BBCO_PC_RESET 21'h000000
`define BBCO_STATUS_RESET 5'h00
`define BBCO_W_RESET 8'h00
`define BBCO_NOP_CYCLES 4

`endif

//--- src/bbco_pkg.sv
/*
  Types shared by the execution block: instruction phase, cycle kind, decoded op.
  Assumes nothing of its surroundings.
*/
package bbco_pkg;
  typedef enum logic [3:0] {
    BBCO_Q1 = 4'b0001,
    BBCO_Q2 = 4'b0010,
    BBCO_Q3 = 4'b0100,
    BBCO_Q4 = 4'b1000
  } bbco_phase_e;

  typedef enum logic [1:0] {
    BBCO_CYC_EXEC = 2'b01,
    BBCO_CYC_NOP = 2'b10
  } bbco_cycle_e;

  typedef enum logic [2:0] {
    BBCO_OP_NONE,
    BBCO_OP_BITINV,
    BBCO_OP_BOV,
    BBCO_OP_BNULL,
    BBCO_OP_CALL,
    BBCO_OP_FILE_CLEAR_OP,
    BBCO_OP_WATCHDOG_CLEAR_OP,
    BBCO_OP_FILE_INVERT_OP
  } bbco_op_e;
endpackage

//--- src/bbco_exec.sv
/*
  Four-phase execution of bit invert, conditional branch, call, file clear,
  watchdog clear and file invert.
  Assumes one clock edge per phase, the fetched word on instr_in during Q1 and
  the second call word during Q4, and data memory answering rd_en in Q2 with
  data during Q3.
*/
`timescale 1ns/10ps
`include "bbco_map.svh"

module bbco_exec (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Program memory
  input wire logic [15:0] instr_in,
  output logic [20:0] pc_out,
  // Data memory
  output logic [11:0] dmem_addr_out,
  output logic dmem_rd_en_out,
  input wire logic [7:0] dmem_rd_data_in,
  output logic dmem_wr_en_out,
  output logic [7:0] dmem_wr_data_out,
  // Core context
  input wire logic [3:0] bank_select_in,
  input wire logic ext_set_en_in,
  input wire logic [11:0] index_base_in,
  // Return stack
  output logic stack_push_out,
  output logic [20:0] top_of_stack_out,
  // Working state and shadows
  output logic [7:0] w_out,
  output logic [4:0] status_out,
  output logic [7:0] accumulator_shadow_out,
  output logic [4:0] flags_shadow_out,
  output logic [3:0] bank_select_shadow_out,
  // Watchdog
  output logic wdt_clear_out,
  output logic timeout_flag_low_out,
  output logic sleep_flag_low_out
);

  bbco_pkg::bbco_phase_e phase_reg;
  bbco_pkg::bbco_cycle_e cyc_reg;
  bbco_pkg::bbco_op_e op_reg, op_next;
  logic [15:0] ir_reg;
  logic [20:0] pc_reg;
  logic [7:0] w_reg, result_reg;
  logic [4:0] status_reg;
  logic [11:0] addr_next;
  logic [20:0] br_offset;
  logic [7:0] bit_mask;
  logic taken;

  ////////////////////////////////////////////////////////////////////////
  // Decode

  always_comb begin
    op_next = bbco_pkg::BBCO_OP_NONE;
    if (instr_in[15:12] == `BBCO_OPC_BITINV) begin
      op_next = bbco_pkg::BBCO_OP_BITINV;
    end else if (instr_in[15:8] == `BBCO_OPC_BOV) begin
      op_next = bbco_pkg::BBCO_OP_BOV;
    end else if (instr_in[15:8] == `BBCO_OPC_BNULL) begin
      op_next = bbco_pkg::BBCO_OP_BNULL;
    end else if (instr_in[15:9] == `BBCO_OPC_CALL) begin
      op_next = bbco_pkg::BBCO_OP_CALL;
    end else if (instr_in[15:9] == `BBCO_OPC_FILE_CLEAR_OP) begin
      op_next = bbco_pkg::BBCO_OP_FILE_CLEAR_OP;
    end else if (instr_in == `BBCO_OPC_WATCHDOG_CLEAR_OP) begin
      op_next = bbco_pkg::BBCO_OP_WATCHDOG_CLEAR_OP;
    end else if (instr_in[15:10] == `BBCO_OPC_FILE_INVERT_OP) begin
      op_next = bbco_pkg::BBCO_OP_FILE_INVERT_OP;
    end
  end

  // Data address from access flag, bank select and extended set
  always_comb begin
    if (instr_in[8]) begin
      addr_next = {bank_select_in, instr_in[7:0]};
    end else if (ext_set_en_in && instr_in[7:0] <= `BBCO_INDEX_LIMIT) begin
      addr_next = index_base_in + {4'h0, instr_in[7:0]};
    end else if (instr_in[7:0] >= `BBCO_ACCESS_SPLIT) begin
      addr_next = {`BBCO_ACCESS_HIGH_BANK, instr_in[7:0]};
    end else begin
      addr_next = {4'h0, instr_in[7:0]};
    end
  end

  assign br_offset = {{12{ir_reg[7]}}, ir_reg[7:0], 1'b0};
  assign bit_mask = 8'h01 << ir_reg[11:9];
  assign taken = (op_reg == bbco_pkg::BBCO_OP_BOV && status_reg[`BBCO_ST_OV]) ||
                 (op_reg == bbco_pkg::BBCO_OP_BNULL && status_reg[`BBCO_ST_Z]);

  ////////////////////////////////////////////////////////////////////////
  // Phase and cycle sequencing

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      phase_reg <= bbco_pkg::BBCO_Q1;
    end else begin
      case (phase_reg)
        bbco_pkg::BBCO_Q1: phase_reg <= bbco_pkg::BBCO_Q2;
        bbco_pkg::BBCO_Q2: phase_reg <= bbco_pkg::BBCO_Q3;
        bbco_pkg::BBCO_Q3: phase_reg <= bbco_pkg::BBCO_Q4;
        bbco_pkg::BBCO_Q4: phase_reg <= bbco_pkg::BBCO_Q1;
        default: phase_reg <= bbco_pkg::BBCO_Q1;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      cyc_reg <= bbco_pkg::BBCO_CYC_EXEC;
    end else if (phase_reg == bbco_pkg::BBCO_Q4) begin
      case (cyc_reg)
        bbco_pkg::BBCO_CYC_EXEC: begin
          if (taken || op_reg == bbco_pkg::BBCO_OP_CALL) begin
            cyc_reg <= bbco_pkg::BBCO_CYC_NOP;
          end
        end
        bbco_pkg::BBCO_CYC_NOP: cyc_reg <= bbco_pkg::BBCO_CYC_EXEC;
        default: cyc_reg <= bbco_pkg::BBCO_CYC_EXEC;
      endcase
    end
  end

  // Fetch latch; idle cycle holds no operation
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      ir_reg <= 16'h0000;
      op_reg <= bbco_pkg::BBCO_OP_NONE;
      dmem_addr_out <= 12'h000;
    end else if (phase_reg == bbco_pkg::BBCO_Q1) begin
      ir_reg <= instr_in;
      dmem_addr_out <= addr_next;
      op_reg <= (cyc_reg == bbco_pkg::BBCO_CYC_EXEC) ? op_next : bbco_pkg::BBCO_OP_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Program counter and return stack

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      pc_reg <= `BBCO_PC_RESET;
    end else if (phase_reg == bbco_pkg::BBCO_Q1 && cyc_reg == bbco_pkg::BBCO_CYC_EXEC) begin
      pc_reg <= pc_reg + `BBCO_PC_STEP;
    end else if (phase_reg == bbco_pkg::BBCO_Q4 && taken) begin
      pc_reg <= pc_reg + br_offset;
    end else if (phase_reg == bbco_pkg::BBCO_Q4 && op_reg == bbco_pkg::BBCO_OP_CALL) begin
      pc_reg <= {instr_in[11:0], ir_reg[7:0], 1'b0};
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      stack_push_out <= 1'b0;
      top_of_stack_out <= `BBCO_PC_RESET;
    end else begin
      stack_push_out <= phase_reg == bbco_pkg::BBCO_Q3 && op_reg == bbco_pkg::BBCO_OP_CALL;
      if (phase_reg == bbco_pkg::BBCO_Q3 && op_reg == bbco_pkg::BBCO_OP_CALL) begin
        top_of_stack_out <= pc_reg + `BBCO_PC_STEP;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      accumulator_shadow_out <= `BBCO_W_RESET;
      flags_shadow_out <= `BBCO_STATUS_RESET;
      bank_select_shadow_out <= 4'h0;
    end else if (phase_reg == bbco_pkg::BBCO_Q4 && op_reg == bbco_pkg::BBCO_OP_CALL && ir_reg[8]) begin
      accumulator_shadow_out <= w_reg;
      flags_shadow_out <= status_reg;
      bank_select_shadow_out <= bank_select_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data path: read Q2, process Q3, write Q4

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      dmem_rd_en_out <= 1'b0;
    end else begin
      dmem_rd_en_out <= phase_reg == bbco_pkg::BBCO_Q1 && cyc_reg == bbco_pkg::BBCO_CYC_EXEC &&
                        (op_next == bbco_pkg::BBCO_OP_BITINV || op_next == bbco_pkg::BBCO_OP_FILE_CLEAR_OP ||
                         op_next == bbco_pkg::BBCO_OP_FILE_INVERT_OP);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      result_reg <= 8'h00;
      dmem_wr_en_out <= 1'b0;
      dmem_wr_data_out <= 8'h00;
    end else begin
      dmem_wr_en_out <= 1'b0;
      if (phase_reg == bbco_pkg::BBCO_Q3) begin
        case (op_reg)
          bbco_pkg::BBCO_OP_BITINV: begin
            result_reg <= dmem_rd_data_in ^ bit_mask;
            dmem_wr_data_out <= dmem_rd_data_in ^ bit_mask;
            dmem_wr_en_out <= 1'b1;
          end
          bbco_pkg::BBCO_OP_FILE_CLEAR_OP: begin
            result_reg <= 8'h00;
            dmem_wr_data_out <= 8'h00;
            dmem_wr_en_out <= 1'b1;
          end
          bbco_pkg::BBCO_OP_FILE_INVERT_OP: begin
            result_reg <= ~dmem_rd_data_in;
            dmem_wr_data_out <= ~dmem_rd_data_in;
            dmem_wr_en_out <= ir_reg[9];
          end
          default: result_reg <= result_reg;
        endcase
      end
    end
  end

  // Accumulator and flags update at end of Q4
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      w_reg <= `BBCO_W_RESET;
      status_reg <= `BBCO_STATUS_RESET;
    end else if (phase_reg == bbco_pkg::BBCO_Q4) begin
      if (op_reg == bbco_pkg::BBCO_OP_FILE_CLEAR_OP) begin
        status_reg[`BBCO_ST_Z] <= 1'b1;
      end else if (op_reg == bbco_pkg::BBCO_OP_FILE_INVERT_OP) begin
        status_reg[`BBCO_ST_N] <= result_reg[7];
        status_reg[`BBCO_ST_Z] <= result_reg == 8'h00;
        if (!ir_reg[9]) begin
          w_reg <= result_reg;
        end
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      wdt_clear_out <= 1'b0;
      timeout_flag_low_out <= 1'b1;
      sleep_flag_low_out <= 1'b1;
    end else begin
      wdt_clear_out <= phase_reg == bbco_pkg::BBCO_Q3 && op_reg == bbco_pkg::BBCO_OP_WATCHDOG_CLEAR_OP;
      if (phase_reg == bbco_pkg::BBCO_Q3 && op_reg == bbco_pkg::BBCO_OP_WATCHDOG_CLEAR_OP) begin
        timeout_flag_low_out <= 1'b1;
        sleep_flag_low_out <= 1'b1;
      end
    end
  end

  assign pc_out = pc_reg;
  assign w_out = w_reg;
  assign status_out = status_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  AST_ACCESS_LOW: assert property (
    (phase_reg == bbco_pkg::BBCO_Q1 && !instr_in[8] && !ext_set_en_in && instr_in[7:0] < 8'h60)
    |=> dmem_addr_out == {4'h0, $past(instr_in[7:0])}) else $error("access bank address wrong");
  AST_BITINV_WRITE: assert property (
    (phase_reg == bbco_pkg::BBCO_Q3 && op_reg == bbco_pkg::BBCO_OP_BITINV)
    |=> dmem_wr_en_out && dmem_wr_data_out == ($past(dmem_rd_data_in) ^ $past(bit_mask)))
    else $error("bit invert result wrong");
  AST_BRANCH_FLAGS: assert property (
    (phase_reg == bbco_pkg::BBCO_Q4 && (op_reg == bbco_pkg::BBCO_OP_BOV || op_reg == bbco_pkg::BBCO_OP_BNULL))
    |=> $stable(status_reg)) else $error("branch altered flags");
  AST_BRANCH_TARGET: assert property (
    (phase_reg == bbco_pkg::BBCO_Q4 && taken) |=> pc_reg == $past(pc_reg) + $past(br_offset))
    else $error("branch target wrong");
  AST_BRANCH_IDLE: assert property (
    (phase_reg == bbco_pkg::BBCO_Q4 && taken) |=> (cyc_reg == bbco_pkg::BBCO_CYC_NOP) [*4])
    else $error("taken branch lacks idle cycle");
  AST_NOT_TAKEN: assert property (
    (phase_reg == bbco_pkg::BBCO_Q4 && op_reg == bbco_pkg::BBCO_OP_BNULL && !status_reg[`BBCO_ST_Z])
    |=> $stable(pc_reg) && cyc_reg == bbco_pkg::BBCO_CYC_EXEC) else $error("untaken branch moved");
  AST_CALL_PUSH: assert property (
    (phase_reg == bbco_pkg::BBCO_Q3 && op_reg == bbco_pkg::BBCO_OP_CALL)
    |=> stack_push_out && top_of_stack_out == $past(pc_reg) + 21'h000002) else $error("return address wrong");
  AST_CALL_LOAD: assert property (
    (phase_reg == bbco_pkg::BBCO_Q4 && op_reg == bbco_pkg::BBCO_OP_CALL)
    |=> pc_reg == {$past(instr_in[11:0]), $past(ir_reg[7:0]), 1'b0} ##4 $stable(pc_reg))
    else $error("call target wrong");
  AST_CALL_SHADOW: assert property (
    (phase_reg == bbco_pkg::BBCO_Q4 && op_reg == bbco_pkg::BBCO_OP_CALL && ir_reg[8])
    |=> accumulator_shadow_out == $past(w_reg) && flags_shadow_out == $past(status_reg))
    else $error("shadow copy missing");
  AST_FILE_CLEAR_OP_ZERO: assert property (
    (phase_reg == bbco_pkg::BBCO_Q3 && op_reg == bbco_pkg::BBCO_OP_FILE_CLEAR_OP)
    |=> dmem_wr_en_out && dmem_wr_data_out == 8'h00 ##1 status_reg[`BBCO_ST_Z]) else $error("file clear wrong");
  AST_WDT_CLEAR: assert property (
    (phase_reg == bbco_pkg::BBCO_Q3 && op_reg == bbco_pkg::BBCO_OP_WATCHDOG_CLEAR_OP)
    |=> wdt_clear_out && timeout_flag_low_out && sleep_flag_low_out) else $error("watchdog clear wrong");
  AST_FILE_INVERT_OP_W: assert property (
    (phase_reg == bbco_pkg::BBCO_Q3 && op_reg == bbco_pkg::BBCO_OP_FILE_INVERT_OP && !ir_reg[9])
    |=> !dmem_wr_en_out ##1 w_reg == ~$past(dmem_rd_data_in, 2)) else $error("invert to accumulator wrong");

  COV_TAKEN: cover property (phase_reg == bbco_pkg::BBCO_Q4 && taken);
  COV_CALL_SHADOW: cover property (phase_reg == bbco_pkg::BBCO_Q4 && op_reg == bbco_pkg::BBCO_OP_CALL && ir_reg[8]);
  COV_INDEXED: cover property (phase_reg == bbco_pkg::BBCO_Q1 && !instr_in[8] && ext_set_en_in);
  COV_FILE_INVERT_OP_FILE: cover property (dmem_wr_en_out && op_reg == bbco_pkg::BBCO_OP_FILE_INVERT_OP);

endmodule // bbco_exec

//--- testbench/bbco_mem_model.sv
/*
  Program and data memory seen by the execution block.
  Assumes the bench preloads both arrays by hierarchical reference.
*/
`timescale 1ns/10ps
module bbco_mem_model (
  // Clock
  input wire logic core_clk_in,
  // Program memory
  input wire logic [20:0] pc_in,
  output logic [15:0] instr_out,
  // Data memory
  input wire logic [11:0] addr_in,
  input wire logic rd_en_in,
  output logic [7:0] rd_data_out,
  input wire logic wr_en_in,
  input wire logic [7:0] wr_data_in
);
  logic [15:0] prog [0:2047];
  logic [7:0] dmem [0:4095];
  logic [7:0] rd_reg = 8'hA5;

  assign instr_out = prog[pc_in[11:1]];
  assign rd_data_out = rd_reg;

  // Read data stands one phase after the strobe, then turns over
  // Plain always: the bench also preloads both arrays
  always @(posedge core_clk_in) begin
    rd_reg <= rd_en_in ? dmem[addr_in] : ~rd_reg;
    if (wr_en_in) begin
      dmem[addr_in] <= wr_data_in;
    end
  end
endmodule // bbco_mem_model

//--- testbench/tb.sv
/*
  Self-checking bench: corner-case and random instructions against expectations
  worked out here.
  Assumes the memory model answers the program and data buses.
*/
`timescale 1ns/10ps
module tb;
  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [3:0] bank_select_in = 4'h0;
  logic ext_set_en_in = 1'b0;
  logic [11:0] index_base_in = 12'h000;
  logic [15:0] instr_in;
  logic [20:0] pc_out, top_of_stack_out, e_pc;
  logic [11:0] dmem_addr_out;
  logic [7:0] dmem_rd_data_in, dmem_wr_data_out, w_out, accumulator_shadow_out, e_w, e_ws;
  logic dmem_rd_en_out, dmem_wr_en_out, stack_push_out, wdt_clear_out, timeout_flag_low_out, sleep_flag_low_out;
  logic [4:0] status_out, flags_shadow_out, e_st, e_ss;
  logic [3:0] bank_select_shadow_out, e_bs;
  logic [31:0] seed = 32'h0000B875;
  logic [31:0] r, r2;
  int n_mismatch = 0;
  int n_compared = 0;
  int cycles = 0;

  bbco_exec bbco_exec_i (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .instr_in(instr_in), .pc_out(pc_out),
    .dmem_addr_out(dmem_addr_out), .dmem_rd_en_out(dmem_rd_en_out), .dmem_rd_data_in(dmem_rd_data_in),
    .dmem_wr_en_out(dmem_wr_en_out), .dmem_wr_data_out(dmem_wr_data_out), .bank_select_in(bank_select_in),
    .ext_set_en_in(ext_set_en_in), .index_base_in(index_base_in), .stack_push_out(stack_push_out),
    .top_of_stack_out(top_of_stack_out), .w_out(w_out), .status_out(status_out),
    .accumulator_shadow_out(accumulator_shadow_out), .flags_shadow_out(flags_shadow_out),
    .bank_select_shadow_out(bank_select_shadow_out), .wdt_clear_out(wdt_clear_out),
    .timeout_flag_low_out(timeout_flag_low_out), .sleep_flag_low_out(sleep_flag_low_out));

  bbco_mem_model bbco_mem_model_i (.core_clk_in(core_clk_in), .pc_in(pc_out), .instr_out(instr_in),
    .addr_in(dmem_addr_out), .rd_en_in(dmem_rd_en_out), .rd_data_out(dmem_rd_data_in),
    .wr_en_in(dmem_wr_en_out), .wr_data_in(dmem_wr_data_out));

  initial begin
    forever #10 core_clk_in = ~core_clk_in;
  end

  always @(posedge core_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      n_mismatch++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [11:0] f_addr(logic a, logic [7:0] f);
    if (a) return {bank_select_in, f};
    if (ext_set_en_in && f <= 8'h5F) return index_base_in + {4'h0, f};
    return {(f >= 8'h60) ? 4'hF : 4'h0, f};
  endfunction

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // One instruction from its Q1 phase to the Q1 phase that follows it
  task automatic step(logic [15:0] iw, logic [15:0] iw2, logic mem, logic [11:0] ad, logic wr,
                      logic [7:0] wd, logic push, logic wdt, int idle, logic [20:0] nx);
    bbco_mem_model_i.prog[e_pc[11:1]] = iw;
    bbco_mem_model_i.prog[e_pc[11:1] + 11'h001] = iw2;
    @(posedge core_clk_in);
    #1;
    if (mem) chk(32'(dmem_addr_out), 32'(ad));
    chk(32'(dmem_rd_en_out), 32'(mem));
    repeat (2) @(posedge core_clk_in);
    #1;
    chk(32'(dmem_wr_en_out), 32'(wr));
    if (wr) chk(32'(dmem_wr_data_out), 32'(wd));
    chk(32'(stack_push_out), 32'(push));
    chk(32'(wdt_clear_out), 32'(wdt));
    repeat (1 + idle) @(posedge core_clk_in);
    #1;
    e_pc = nx;
    chk(32'(pc_out), 32'(nx));
    chk(32'(w_out), 32'(e_w));
    chk(32'(status_out), 32'(e_st));
  endtask

  task automatic op(int k, logic [7:0] f, logic a, logic [2:0] b, logic d, logic [7:0] v);
    logic [11:0] ad;
    logic [7:0] x;
    logic [19:0] kk;
    logic [20:0] nx, here;
    logic tk;
    ad = f_addr(a, f);
    kk = 20'(rnd());
    here = e_pc;
    nx = e_pc + 21'h000002;
    bbco_mem_model_i.dmem[ad] = v;
    case (k)
      0: begin
        x = v ^ (8'h01 << b);
        step({4'h7, b, a, f}, 16'h0000, 1'b1, ad, 1'b1, x, 1'b0, 1'b0, 0, nx);
      end
      1: begin
        e_st[2] = 1'b1;
        x = 8'h00;
        step({7'h35, a, f}, 16'h0000, 1'b1, ad, 1'b1, x, 1'b0, 1'b0, 0, nx);
      end
      2: begin
        x = d ? ~v : v;
        e_st[4] = ~v[7];
        e_st[2] = (v == 8'hFF);
        if (!d) e_w = ~v;
        step({6'h07, d, a, f}, 16'h0000, 1'b1, ad, d, ~v, 1'b0, 1'b0, 0, nx);
      end
      3, 4: begin
        tk = (k == 3) ? e_st[2] : e_st[3];
        if (tk) nx = nx + {{12{f[7]}}, f, 1'b0};
        step({(k == 3) ? 8'hE0 : 8'hE4, f}, 16'h0000, 1'b0, ad, 1'b0, 8'h00, 1'b0, 1'b0, tk ? 4 : 0, nx);
      end
      5: begin
        if (a) {e_ws, e_ss, e_bs} = {e_w, e_st, bank_select_in};
        step({7'h76, a, kk[7:0]}, {4'hF, kk[19:8]}, 1'b0, ad, 1'b0, 8'h00, 1'b1, 1'b0, 4, {kk, 1'b0});
        chk(32'(top_of_stack_out), 32'(here + 21'h000004));
        chk(32'({accumulator_shadow_out, flags_shadow_out, bank_select_shadow_out}), 32'({e_ws, e_ss, e_bs}));
      end
      default: begin
        step(16'h0004, 16'h0000, 1'b0, ad, 1'b0, 8'h00, 1'b0, 1'b1, 0, nx);
        chk(32'({timeout_flag_low_out, sleep_flag_low_out}), 32'h00000003);
      end
    endcase
    if (k < 3) chk(32'(bbco_mem_model_i.dmem[ad]), 32'(x));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < 2048; i++) bbco_mem_model_i.prog[i] = 16'h0000;
    {e_pc, e_w, e_st, e_ws, e_ss, e_bs} = '0;
    repeat (6) @(posedge core_clk_in);
    #1;
    rst_n_in = 1'b1;
    // Corner cases: access split, branch extremes, shadow on and off
    op(1, 8'h5F, 1'b0, 3'h0, 1'b0, 8'h5A);
    op(3, 8'h80, 1'b0, 3'h0, 1'b0, 8'h00);
    op(2, 8'h60, 1'b0, 3'h0, 1'b1, 8'hFF);
    op(3, 8'h7F, 1'b0, 3'h0, 1'b0, 8'h00);
    op(0, 8'hFF, 1'b1, 3'h7, 1'b0, 8'h75);
    op(5, 8'h00, 1'b1, 3'h0, 1'b0, 8'h00);
    op(2, 8'h10, 1'b0, 3'h0, 1'b0, 8'h13);
    op(5, 8'h00, 1'b0, 3'h0, 1'b0, 8'h00);
    op(6, 8'h00, 1'b0, 3'h0, 1'b0, 8'h00);
    op(3, 8'h05, 1'b0, 3'h0, 1'b0, 8'h00);
    op(4, 8'h05, 1'b0, 3'h0, 1'b0, 8'h00);
    ext_set_en_in = 1'b1;
    index_base_in = 12'h3A0;
    op(0, 8'h5F, 1'b0, 3'h3, 1'b0, 8'h0F);
    op(0, 8'h60, 1'b0, 3'h0, 1'b0, 8'h0F);
    // Random mix
    repeat (300) begin
      r = rnd();
      r2 = rnd();
      bank_select_in = r[3:0];
      ext_set_en_in = r[4];
      index_base_in = r[31:20];
      op(int'(r[10:8]) % 7, r2[7:0], r2[8], r2[11:9], r2[12], r2[20:13]);
    end
    summarize();
  end
endmodule // tb
